// File: logic/cmp_event_pkg.sv
// Package: register map, field positions and sense encodings for the
// comparator event conditioner. Assumes a 32-bit byte-addressed plain port.
package cmp_event_pkg;
   localparam logic [7:0] CTRL_OFFSET = 8'h24;
   localparam logic [7:0] STAT_OFFSET = 8'h20;
   localparam logic [7:0] IRQ_EN_OFFSET = 8'h10;
   localparam logic [7:0] EVT_STAT_OFFSET = 8'h30;
   localparam logic [7:0] EVT_MASK_OFFSET = 8'h34;
   localparam int INV_BIT = 1;
   localparam int IRQ_SENSE_SELECT_LO = 2;
   localparam int ILVL_BIT = 4;
   localparam int ADC_TRIGGER_SENSE_SELECT_LO = 5;
   localparam int TLVL_BIT = 7;
   localparam int ADC_EVENT_FORWARD_ENABLE_BIT = 11;
   localparam int COMPARATOR_OUTPUT_STATUS_BIT = 1;
   localparam int IEN_BIT = 0;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_08FE;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] EVT_STAT_RESET = 2'h0;
   localparam logic [1:0] EVT_MASK_RESET = 2'h0;
   typedef enum logic [1:0] {
      SENSE_LEVEL = 2'h0,
      SENSE_FALL = 2'h1,
      SENSE_RISE = 2'h2,
      SENSE_BOTH = 2'h3
   } sense_t;
endpackage

// File: logic/cmp_sense_if.sv
// Interface: conditioned comparator level and its previous value, shared
// between the top and the sense qualifier.
`timescale 1ns/1ps
`default_nettype none
interface cmp_sense_if;
   logic level;
   logic prev;
   modport src (output level, output prev);
   modport snk (input level, input prev);
endinterface
`default_nettype wire

// File: logic/cmp_sense_qual.sv
// Sense qualifier: turns level and previous level into a hit per sense mode.
// Assumes both inputs are registered in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module cmp_sense_qual
   import cmp_event_pkg::*;
(
   cmp_sense_if.snk sig,              // Conditioned level pair
   input wire logic [1:0] sense_i,    // Sense mode select
   input wire logic lvl_val_i,        // Level-mode active value
   output logic hit_o                 // Qualified condition
);
   always_comb begin
      unique case (sense_t'(sense_i))
         SENSE_LEVEL: hit_o = (sig.level == lvl_val_i);
         SENSE_FALL: hit_o = sig.prev & ~sig.level;
         SENSE_RISE: hit_o = ~sig.prev & sig.level;
         SENSE_BOTH: hit_o = sig.prev ^ sig.level;
      endcase
   end
endmodule
`default_nettype wire

// File: logic/cmp_event_cond.sv
// Comparator event conditioner: invert, sense for irq and ADC trigger,
// register port. Assumes comparator output is already synchronous to mclk_i.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: Trigger sense from bits 6:5
// R02: Irq level mode follows level-value bit 4
// R03: Irq sense from bits 3:2
// R04: Invert bit 1 complements output first
// R05: Trigger level mode follows trigger level bit
// R06: Forward ADC events only when enabled
// R07: Pass irq only when irq enabled; masked sticky events also raise irq_o while the irq enable is clear
// R08: Status bit 1 shows output value
// R09: Edges compare with previous cycle value
module cmp_event_cond
   import cmp_event_pkg::*;
(
   input wire logic mclk_i,           // System clock
   input wire logic rstn_i,           // Async reset, active low
   input wire logic cmp_out_i,        // Raw comparator output
   input wire logic [7:0] addr_i,     // Register byte address
   input wire logic [31:0] wdata_i,   // Write data
   input wire logic wr_i,             // Write strobe
   input wire logic rd_i,             // Read strobe
   output logic [31:0] rdata_o,       // Read data, cycle after rd_i
   output logic irq_o,                // Level interrupt request
   output logic adc_trig_o            // ADC trigger event
);
   logic [31:0] ctrl_q, ctrl_d;
   logic ien_q, ien_d;
   logic [1:0] est_q, est_d;
   logic [1:0] emask_q, emask_d;
   logic [31:0] rdata_q, rdata_d;
   logic lvl_q, lvl_d;
   logic prev_q, prev_d;
   logic irq_q, irq_d;
   logic trig_q, trig_d;
   logic irq_hit, trig_hit;
   cmp_sense_if irq_sig ();
   cmp_sense_if trg_sig ();

   assign irq_sig.level = lvl_q;
   assign irq_sig.prev = prev_q;
   assign trg_sig.level = lvl_q;
   assign trg_sig.prev = prev_q;

   cmp_sense_qual u_irq (
      .sig(irq_sig.snk),
      .sense_i(ctrl_q[IRQ_SENSE_SELECT_LO +: 2]),  // R03
      .lvl_val_i(ctrl_q[ILVL_BIT]),    // R02
      .hit_o(irq_hit)
   );
   cmp_sense_qual u_trg (
      .sig(trg_sig.snk),
      .sense_i(ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2]),  // R01
      .lvl_val_i(ctrl_q[TLVL_BIT]),    // R05
      .hit_o(trig_hit)
   );

   // Configuration registers and sticky event status
   always_comb begin
      ctrl_d = ctrl_q;
      ien_d = ien_q;
      emask_d = emask_q;
      est_d = est_q;
      if (wr_i) begin
         unique case (addr_i)
            CTRL_OFFSET: ctrl_d = wdata_i & CTRL_WMASK;
            IRQ_EN_OFFSET: ien_d = wdata_i[IEN_BIT];
            EVT_MASK_OFFSET: emask_d = wdata_i[1:0];
            EVT_STAT_OFFSET: est_d = est_q & ~wdata_i[1:0];
            default: ;
         endcase
      end
      // Set wins over write-one-to-clear
      est_d = est_d | {trig_hit, irq_hit};
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= CTRL_RESET;
         ien_q <= 1'b0;
         est_q <= EVT_STAT_RESET;
         emask_q <= EVT_MASK_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         ien_q <= ien_d;
         est_q <= est_d;
         emask_q <= emask_d;
      end
   end

   // Conditioned level and its one-cycle history
   always_comb begin
      lvl_d = cmp_out_i ^ ctrl_q[INV_BIT]; // R04
      prev_d = lvl_q; // R09
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lvl_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         lvl_q <= lvl_d;
         prev_q <= prev_d;
      end
   end

   // Read data and both outputs
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_i) begin
         unique case (addr_i)
            CTRL_OFFSET: rdata_d = ctrl_q;
            STAT_OFFSET: rdata_d[COMPARATOR_OUTPUT_STATUS_BIT] = lvl_q; // R08
            IRQ_EN_OFFSET: rdata_d[IEN_BIT] = ien_q;
            EVT_STAT_OFFSET: rdata_d[1:0] = est_q;
            EVT_MASK_OFFSET: rdata_d[1:0] = emask_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      // Next status, so a clear drops the sticky request at once
      irq_d = (ien_q & irq_hit) | (|(est_d & emask_d)); // R07
      trig_d = ctrl_q[ADC_EVENT_FORWARD_ENABLE_BIT] & trig_hit; // R06
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= 32'h0000_0000;
         irq_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         trig_q <= trig_d;
      end
   end

   assign rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign adc_trig_o = trig_q;

   invert_path_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R04
      lvl_q == ($past(cmp_out_i) ^ $past(ctrl_q[INV_BIT])))
      else $error("conditioned level wrong");
   edge_history_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R09
      prev_q == $past(lvl_q)) else $error("previous level not tracked");
   trig_rise_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == 2'h2 && ctrl_q[ADC_EVENT_FORWARD_ENABLE_BIT] && !prev_q && lvl_q) |=> adc_trig_o)
      else $error("rising trigger missed");
   trig_fall_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == 2'h1 && !(prev_q && !lvl_q)) |=> !adc_trig_o)
      else $error("falling trigger spurious");
   trig_level_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R05
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == 2'h0 && ctrl_q[ADC_EVENT_FORWARD_ENABLE_BIT]) |=>
      (adc_trig_o == ($past(lvl_q) == $past(ctrl_q[TLVL_BIT]))))
      else $error("level trigger wrong");
   trig_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R06
      !ctrl_q[ADC_EVENT_FORWARD_ENABLE_BIT] |=> !adc_trig_o) else $error("trigger not suppressed");
   irq_level_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R02
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == 2'h0 && ien_q && lvl_q == ctrl_q[ILVL_BIT]) |=> irq_o)
      else $error("level irq missed");
   irq_both_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == 2'h3 && ien_q && prev_q != lvl_q) |=> irq_o)
      else $error("either-edge irq missed");
   irq_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R07
      (!ien_q ##1 ((est_q & emask_q) == 2'h0)) |-> !irq_o)
      else $error("irq not gated");
   status_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R08
      (rd_i && addr_i == STAT_OFFSET) |=> rdata_o[COMPARATOR_OUTPUT_STATUS_BIT] == $past(lvl_q))
      else $error("status bit wrong");

   // Remaining sense modes on both paths
   irq_rise_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == SENSE_RISE && ien_q && !prev_q && lvl_q) |=> irq_o)
      else $error("rising irq missed");
   irq_fall_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == SENSE_FALL && ien_q && prev_q && !lvl_q) |=> irq_o)
      else $error("falling irq missed");
   irq_edge_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == SENSE_RISE && !(!prev_q && lvl_q)) ##1
      ((est_q & emask_q) == 2'h0) |-> !irq_o) else $error("rising irq spurious");
   irq_low_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R02
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == SENSE_LEVEL && ien_q && !ctrl_q[ILVL_BIT] && !lvl_q) |=> irq_o)
      else $error("low level irq missed");
   trig_both_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == SENSE_BOTH && ctrl_q[ADC_EVENT_FORWARD_ENABLE_BIT] && prev_q != lvl_q) |=> adc_trig_o)
      else $error("either-edge trigger missed");
   trig_fall_hit_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == SENSE_FALL && ctrl_q[ADC_EVENT_FORWARD_ENABLE_BIT] && prev_q && !lvl_q) |=> adc_trig_o)
      else $error("falling trigger missed");
   trig_rise_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == SENSE_RISE && !(!prev_q && lvl_q)) |=> !adc_trig_o)
      else $error("rising trigger spurious");

   // Register port and sticky status
   evt_irq_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      (ctrl_q[IRQ_SENSE_SELECT_LO +: 2] == SENSE_RISE && !prev_q && lvl_q) |=> est_q[0])
      else $error("irq event not latched");
   evt_trig_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (ctrl_q[ADC_TRIGGER_SENSE_SELECT_LO +: 2] == SENSE_RISE && !prev_q && lvl_q) |=> est_q[1])
      else $error("trigger event not latched");
   evt_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      (wr_i && addr_i == EVT_STAT_OFFSET && wdata_i[0] && !irq_hit) |=> !est_q[0])
      else $error("irq event not cleared");
   irq_sticky_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R03
      ((est_q & emask_q) != 2'h0) |-> irq_o)
      else $error("sticky irq missing");
   irq_en_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R07
      (wr_i && addr_i == IRQ_EN_OFFSET) |=> ien_q == $past(wdata_i[IEN_BIT]))
      else $error("irq enable not written");
   ctrl_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R04
      (wr_i && addr_i == CTRL_OFFSET) |=> ctrl_q == ($past(wdata_i) & CTRL_WMASK))
      else $error("control not written");
   ctrl_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R01
      (rd_i && addr_i == CTRL_OFFSET) |=> rdata_o == $past(ctrl_q))
      else $error("control read wrong");
   rdata_idle_a: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R08
      !rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data not idle");
endmodule
`default_nettype wire

// File: tb/adc_irq_sink.sv
// Far-side model: ADC trigger input counting sampled event cycles.
// Assumes the trigger is synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module adc_irq_sink (
   input wire logic clk_i,   // System clock
   input wire logic rstn_i,  // Async reset, active low
   input wire logic trig_i,  // ADC trigger event
   output var int cnt_o      // Trigger cycles seen
);
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_o <= 0;
      end else begin
         cnt_o <= cnt_o + int'(trig_i);
      end
   end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench: drives register port and comparator, checks irq and ADC trigger.
// Assumes the sink model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
   import cmp_event_pkg::*;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cmp_out_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [31:0] d;
   logic irq_o;
   logic adc_trig_o;
   int cnt;
   int base;
   int errors = 0;
   int compares = 0;
   always #10 mclk_i = ~mclk_i;
   cmp_event_cond cmp_event_cond_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmp_out_i(cmp_out_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .irq_o(irq_o), .adc_trig_o(adc_trig_o));
   adc_irq_sink adc_irq_sink_i (.clk_i(mclk_i), .rstn_i(rstn_i), .trig_i(adc_trig_o), .cnt_o(cnt));
   task final_report;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Comparator change, outputs settle two edges later
   task cmp(input logic v);
      @(posedge mclk_i);
      cmp_out_i <= v;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
   task t_reset;
      rd(CTRL_OFFSET);
      `CHK("ctrl reset", 32'h0, d)
      rd(8'h3C);
      `CHK("unmapped", 32'h0, d)
   endtask
   task t_level;
      wr(IRQ_EN_OFFSET, 32'h1);
      wr(CTRL_OFFSET, 32'h10);
      cmp(1'b1);
      `CHK("irq high lvl", 1'b1, irq_o)
      cmp(1'b0);
      `CHK("irq low lvl", 1'b0, irq_o)
      wr(CTRL_OFFSET, 32'h2);
      cmp(1'b0);
      `CHK("irq inverted", 1'b0, irq_o)
      rd(STAT_OFFSET);
      `CHK("status", 32'h2, d)
      wr(IRQ_EN_OFFSET, 32'h0);
      wr(CTRL_OFFSET, 32'h0);
      cmp(1'b0);
      `CHK("irq disabled", 1'b0, irq_o)
   endtask
   task t_edges;
      for (int m = 1; m < 4; m++) begin
         wr(CTRL_OFFSET, 32'h800 | (m << 5));
         #1 base = cnt;
         cmp(1'b1);
         `CHK("trig on rise", (m >> 1) & 1, adc_trig_o)
         cmp(1'b0);
         `CHK("trig on fall", m & 1, adc_trig_o)
         repeat (2) @(posedge mclk_i);
         #1 `CHK("trig count", (m >> 1) + (m & 1), cnt - base)
      end
      wr(CTRL_OFFSET, 32'h880);
      cmp(1'b1);
      `CHK("trig level", 1'b1, adc_trig_o)
      wr(CTRL_OFFSET, 32'h080);
      cmp(1'b1);
      `CHK("trig gated", 1'b0, adc_trig_o)
   endtask
   task t_evt;
      wr(CTRL_OFFSET, 32'h8);
      cmp(1'b0);
      wr(EVT_STAT_OFFSET, 32'h3);
      wr(EVT_MASK_OFFSET, 32'h1);
      cmp(1'b1);
      `CHK("irq sticky", 1'b1, irq_o)
      rd(EVT_STAT_OFFSET);
      `CHK("evt bit", 1'b1, d[0])
      wr(EVT_STAT_OFFSET, 32'h1);
      repeat (2) @(posedge mclk_i);
      #1 `CHK("irq cleared", 1'b0, irq_o)
      wr(EVT_MASK_OFFSET, 32'h0);
      wr(IRQ_EN_OFFSET, 32'h1);
      wr(CTRL_OFFSET, 32'h4);
      cmp(1'b0);
      `CHK("irq fall", 1'b1, irq_o)
      @(posedge mclk_i);
      #1 `CHK("irq pulse", 1'b0, irq_o)
      wr(CTRL_OFFSET, 32'hC);
      cmp(1'b1);
      `CHK("irq either", 1'b1, irq_o)
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      rstn_i <= 1'b1;
      t_reset;
      t_level;
      t_edges;
      t_evt;
      final_report;
   end
   initial begin
      repeat (3000) @(posedge mclk_i);
      errors++;
      final_report;
   end
endmodule
`default_nettype wire
